// ==== verilog/deeac_pkg.sv ====
package deeac_pkg;
  // Array geometry
  localparam int DEEAC_ADDR_W     = 5;
  localparam int DEEAC_DATA_W     = 8;
  localparam int DEEAC_DEPTH      = 32;
  // Special-function addresses seen by the core
  localparam logic [7:0] DEEAC_CTRL_OFFSET = 8'h40;
  localparam logic [7:0] DEEAC_ADDR_SFR    = 8'h01;
  localparam logic [7:0] DEEAC_DATA_SFR    = 8'h02;
  localparam logic [7:0] DEEAC_PTR1_SFR    = 8'h03;
  localparam logic [7:0] DEEAC_IND1_SFR    = 8'h04;
  localparam logic [7:0] DEEAC_BANK_SFR    = 8'h05;
  localparam logic [7:0] DEEAC_IRQ_SFR     = 8'h06;
  // Control register fields
  localparam int DEEAC_RD_GO_BIT   = 0;
  localparam int DEEAC_RD_PERM_BIT = 1;
  localparam int DEEAC_WR_GO_BIT   = 2;
  localparam int DEEAC_WR_PERM_BIT = 3;
  // Interrupt register fields
  localparam int DEEAC_GIE_BIT     = 0;
  localparam int DEEAC_NIE_BIT     = 1;
  localparam int DEEAC_NIF_BIT     = 2;
  // Reset values
  localparam logic [7:0] DEEAC_CTRL_RST = 8'h00;
  localparam logic [4:0] DEEAC_ADDR_RST = 5'h00;
  localparam logic [7:0] DEEAC_DATA_RST = 8'h00;
  // Cycle lengths
  localparam int DEEAC_RD_CYCLES   = 4;
  localparam int DEEAC_TMR_CLK_NS  = 1000;
  localparam int DEEAC_CLK_NS      = 8;
  localparam int DEEAC_TMR_DIV     = DEEAC_TMR_CLK_NS / DEEAC_CLK_NS;
  localparam int DEEAC_WR_TICKS    = 8;
  localparam int DEEAC_CNT_W       = 16;
  // Core wait between successive control-register polls
  localparam int DEEAC_POLL_GAP    = 2;
endpackage

// ==== verilog/deeac_if.sv ====
`timescale 1ns/100ps
interface deeac_if (
  input wire logic clk_in,
  input wire logic rst_in
);
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       irq_req;
  logic       irq_ack;
  logic       stack_full;

  modport device (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack, stack_full,
    output sfr_rdata, irq_req
  );
  modport core (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack, stack_full,
    input  sfr_rdata, irq_req
  );
endinterface

// ==== verilog/deeac_device.sv ====
`timescale 1ns/100ps
module deeac_device
  import deeac_pkg::*;
#(
  parameter int RD_CYCLES = deeac_pkg::DEEAC_RD_CYCLES,
  parameter int TMR_DIV   = deeac_pkg::DEEAC_TMR_DIV,
  parameter int WR_TICKS  = deeac_pkg::DEEAC_WR_TICKS
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Core side
  deeac_if.device   bus,
  // Status
  output logic      busy_out,
  output logic      vector_out
);
  import deeac_pkg::*;

  typedef enum logic [2:0] {
    DEEAC_IDLE  = 3'b001,
    DEEAC_READ  = 3'b010,
    DEEAC_WRITE = 3'b100
  } deeac_state_t;

  logic [DEEAC_DATA_W-1:0] mem [DEEAC_DEPTH];
  deeac_state_t            state;
  logic [4:0]              addr;
  logic [7:0]              data;
  logic                    rd_go;
  logic                    rd_perm;
  logic                    wr_go;
  logic                    wr_perm;
  logic                    bank;
  logic [7:0]              ptr1;
  logic                    gie;
  logic                    nie;
  logic                    nif;
  logic [DEEAC_CNT_W-1:0]  cnt;
  logic [DEEAC_CNT_W-1:0]  tdiv;
  logic                    tick;
  logic                    rd_done;
  logic                    wr_done;
  logic                    ctrl_hit;
  logic                    take;
  logic [7:0]              next_rdata;

  function automatic logic sfr_hit(input logic [7:0] a,
                                   input logic [7:0] b);
    sfr_hit = (a == b);
  endfunction

  // Control only reachable indirectly through bank 1
  assign ctrl_hit = sfr_hit(bus.sfr_addr, DEEAC_IND1_SFR) && bank
                    && sfr_hit(ptr1, DEEAC_CTRL_OFFSET);
  assign rd_done  = (state == DEEAC_READ)
                    && (cnt == DEEAC_CNT_W'(RD_CYCLES - 1));
  assign wr_done  = (state == DEEAC_WRITE) && tick
                    && (cnt == DEEAC_CNT_W'(WR_TICKS - 1));
  assign take     = bus.irq_ack && nif && nie && gie;

  // Free-running timebase, independent of access timing
  always_ff @(posedge clk_in) begin
    if (rst_in || tdiv == DEEAC_CNT_W'(TMR_DIV - 1)) begin
      tdiv <= '0;
    end else begin
      tdiv <= tdiv + 1'b1;
    end
  end
  assign tick = (tdiv == DEEAC_CNT_W'(TMR_DIV - 1));

  // Sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= DEEAC_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        DEEAC_IDLE: begin
          cnt <= '0;
          if (ctrl_hit && bus.sfr_wr) begin
            if (bus.sfr_wdata[DEEAC_WR_GO_BIT] && wr_perm) begin
              state <= DEEAC_WRITE;
            end else if (bus.sfr_wdata[DEEAC_RD_GO_BIT] && rd_perm) begin
              state <= DEEAC_READ;
            end
          end
        end
        DEEAC_READ: begin
          cnt <= cnt + 1'b1;
          if (rd_done) begin
            state <= DEEAC_IDLE;
          end
        end
        DEEAC_WRITE: begin
          if (tick) begin
            cnt <= cnt + 1'b1;
          end
          if (wr_done) begin
            state <= DEEAC_IDLE;
          end
        end
        default: state <= DEEAC_IDLE;
      endcase
    end
  end

  // Control register; launches ignored unless idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {rd_go, rd_perm, wr_go, wr_perm} <= 4'h0;
    end else begin
      if (ctrl_hit && bus.sfr_wr) begin
        rd_perm <= bus.sfr_wdata[DEEAC_RD_PERM_BIT];
        wr_perm <= bus.sfr_wdata[DEEAC_WR_PERM_BIT];
      end
      if (state == DEEAC_IDLE && ctrl_hit && bus.sfr_wr) begin
        wr_go <= bus.sfr_wdata[DEEAC_WR_GO_BIT] && wr_perm;
        rd_go <= bus.sfr_wdata[DEEAC_RD_GO_BIT] && rd_perm
                 && !(bus.sfr_wdata[DEEAC_WR_GO_BIT] && wr_perm);
      end
      if (rd_done) begin
        rd_go <= 1'b0;
      end
      if (wr_done) begin
        wr_go <= 1'b0;
      end
    end
  end

  // Address, data, pointer and bank registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr <= DEEAC_ADDR_RST;
      data <= DEEAC_DATA_RST;
      ptr1 <= 8'h00;
      bank <= 1'b0;
    end else begin
      if (bus.sfr_wr && sfr_hit(bus.sfr_addr, DEEAC_ADDR_SFR)) begin
        addr <= bus.sfr_wdata[DEEAC_ADDR_W-1:0];
      end
      if (bus.sfr_wr && sfr_hit(bus.sfr_addr, DEEAC_PTR1_SFR)) begin
        ptr1 <= bus.sfr_wdata;
      end
      if (bus.sfr_wr && sfr_hit(bus.sfr_addr, DEEAC_BANK_SFR)) begin
        bank <= bus.sfr_wdata[0];
      end
      // Read result overrides; core writes ignored during a write cycle
      if (rd_done) begin
        data <= mem[addr];
      end else if (bus.sfr_wr && sfr_hit(bus.sfr_addr, DEEAC_DATA_SFR)
                   && state != DEEAC_WRITE) begin
        data <= bus.sfr_wdata;
      end
    end
  end

  // Array commit at end of the timed write
  always_ff @(posedge clk_in) begin
    if (wr_done) begin
      mem[addr] <= data;
    end
  end

  // Interrupt flag: hardware set wins over any clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gie <= 1'b0;
      nie <= 1'b0;
      nif <= 1'b0;
    end else begin
      if (bus.sfr_wr && sfr_hit(bus.sfr_addr, DEEAC_IRQ_SFR)) begin
        gie <= bus.sfr_wdata[DEEAC_GIE_BIT];
        nie <= bus.sfr_wdata[DEEAC_NIE_BIT];
        nif <= bus.sfr_wdata[DEEAC_NIF_BIT];
      end
      if (take) begin
        nif <= 1'b0;
        gie <= 1'b0;
      end
      if (wr_done) begin
        nif <= 1'b1;
      end
    end
  end

  // Read mux; unused address bits read zero
  always_comb begin
    next_rdata = 8'h00;
    case (1'b1)
      sfr_hit(bus.sfr_addr, DEEAC_ADDR_SFR): next_rdata = {3'h0, addr};
      sfr_hit(bus.sfr_addr, DEEAC_DATA_SFR): next_rdata = data;
      sfr_hit(bus.sfr_addr, DEEAC_PTR1_SFR): next_rdata = ptr1;
      sfr_hit(bus.sfr_addr, DEEAC_BANK_SFR): next_rdata = {7'h00, bank};
      sfr_hit(bus.sfr_addr, DEEAC_IRQ_SFR):
        next_rdata = {5'h00, nif, nie, gie};
      ctrl_hit: next_rdata = {4'h0, wr_perm, wr_go, rd_perm, rd_go};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus.sfr_rdata <= 8'h00;
      bus.irq_req   <= 1'b0;
      busy_out      <= 1'b0;
      vector_out    <= 1'b0;
    end else begin
      bus.sfr_rdata <= next_rdata;
      bus.irq_req   <= nif && nie && gie && !bus.stack_full;
      busy_out      <= (state != DEEAC_IDLE);
      vector_out    <= take && !bus.stack_full;
    end
  end
endmodule

// ==== verilog/deeac_core.sv ====
`timescale 1ns/100ps
module deeac_core
  import deeac_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Device side
  deeac_if.core           bus,
  // User commands
  input  wire logic       rd_req_in,
  input  wire logic       wr_req_in,
  input  wire logic [4:0] addr_in,
  input  wire logic [7:0] data_in,
  input  wire logic       stack_full_in,
  // Results
  output logic            done_out,
  output logic [7:0]      data_out,
  output logic            ready_out
);
  import deeac_pkg::*;

  typedef enum logic [9:0] {
    DEEAC_C_IDLE   = 10'h001,
    DEEAC_C_SETA   = 10'h002,
    DEEAC_C_SETD   = 10'h004,
    DEEAC_C_PTR    = 10'h008,
    DEEAC_C_BANK   = 10'h010,
    DEEAC_C_MASK   = 10'h020,
    DEEAC_C_PERM   = 10'h040,
    DEEAC_C_GO     = 10'h080,
    DEEAC_C_UNMASK = 10'h100,
    DEEAC_C_POLL   = 10'h200
  } deeac_cstate_t;

  deeac_cstate_t state;
  logic          is_wr;
  logic [4:0]    addr;
  logic [7:0]    wdat;
  logic [1:0]    gap;
  logic          fin;
  logic          ack_q;

  // Writes only: interrupts masked around the permit/go pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state         <= DEEAC_C_IDLE;
      is_wr         <= 1'b0;
      addr          <= 5'h00;
      wdat          <= 8'h00;
      gap           <= 2'h0;
      fin           <= 1'b0;
      bus.sfr_wr    <= 1'b0;
      bus.sfr_rd    <= 1'b0;
      bus.sfr_addr  <= 8'h00;
      bus.sfr_wdata <= 8'h00;
      done_out      <= 1'b0;
      data_out      <= 8'h00;
      ready_out     <= 1'b0;
    end else begin
      bus.sfr_wr <= 1'b1;
      bus.sfr_rd <= 1'b0;
      done_out   <= 1'b0;
      ready_out  <= 1'b0;
      case (state)
        DEEAC_C_IDLE: begin
          bus.sfr_wr <= 1'b0;
          ready_out  <= 1'b1;
          if (wr_req_in || rd_req_in) begin
            is_wr     <= wr_req_in;
            addr      <= addr_in;
            wdat      <= data_in;
            ready_out <= 1'b0;
            state     <= DEEAC_C_SETA;
          end
        end
        DEEAC_C_SETA: begin
          bus.sfr_addr  <= DEEAC_ADDR_SFR;
          bus.sfr_wdata <= {3'h0, addr};
          state         <= is_wr ? DEEAC_C_SETD : DEEAC_C_PTR;
        end
        DEEAC_C_SETD: begin
          bus.sfr_addr  <= DEEAC_DATA_SFR;
          bus.sfr_wdata <= wdat;
          state         <= DEEAC_C_PTR;
        end
        DEEAC_C_PTR: begin
          bus.sfr_addr  <= DEEAC_PTR1_SFR;
          bus.sfr_wdata <= DEEAC_CTRL_OFFSET;
          state         <= DEEAC_C_BANK;
        end
        DEEAC_C_BANK: begin
          bus.sfr_addr  <= DEEAC_BANK_SFR;
          bus.sfr_wdata <= 8'h01;
          state         <= is_wr ? DEEAC_C_MASK : DEEAC_C_PERM;
        end
        DEEAC_C_MASK: begin
          // Global enable off, source enable on, flag cleared
          bus.sfr_addr  <= DEEAC_IRQ_SFR;
          bus.sfr_wdata <= 8'h01 << DEEAC_NIE_BIT;
          state         <= DEEAC_C_PERM;
        end
        DEEAC_C_PERM: begin
          bus.sfr_addr  <= DEEAC_IND1_SFR;
          bus.sfr_wdata <= is_wr ? 8'h08 : 8'h02;
          state         <= DEEAC_C_GO;
        end
        DEEAC_C_GO: begin
          // Issued the very next cycle after the permit
          bus.sfr_addr  <= DEEAC_IND1_SFR;
          bus.sfr_wdata <= is_wr ? 8'h0c : 8'h03;
          gap           <= 2'h0;
          fin           <= 1'b0;
          state         <= is_wr ? DEEAC_C_UNMASK : DEEAC_C_POLL;
        end
        DEEAC_C_UNMASK: begin
          bus.sfr_addr  <= DEEAC_IRQ_SFR;
          bus.sfr_wdata <= (8'h01 << DEEAC_NIE_BIT)
                           | (8'h01 << DEEAC_GIE_BIT);
          state         <= DEEAC_C_POLL;
        end
        DEEAC_C_POLL: begin
          bus.sfr_wr   <= 1'b0;
          bus.sfr_rd   <= 1'b1;
          gap          <= gap + 1'b1;
          if (!fin) begin
            bus.sfr_addr <= DEEAC_IND1_SFR;
          end
          if (fin) begin
            // Read data lags its address by one cycle
            if (gap == 2'h1) begin
              bus.sfr_wr    <= 1'b1;
              bus.sfr_rd    <= 1'b0;
              bus.sfr_addr  <= DEEAC_IND1_SFR;
              bus.sfr_wdata <= 8'h00;
              if (!is_wr) begin
                data_out <= bus.sfr_rdata;
              end
            end else if (gap == 2'h2) begin
              bus.sfr_wr    <= 1'b1;
              bus.sfr_rd    <= 1'b0;
              bus.sfr_addr  <= DEEAC_BANK_SFR;
              bus.sfr_wdata <= 8'h00;
              done_out      <= 1'b1;
              state         <= DEEAC_C_IDLE;
            end
          end else if (gap == 2'(DEEAC_POLL_GAP)) begin
            gap <= 2'h0;
            if (bus.sfr_rdata[is_wr ? DEEAC_WR_GO_BIT
                                    : DEEAC_RD_GO_BIT] == 1'b0) begin
              fin           <= 1'b1;
              bus.sfr_addr  <= DEEAC_DATA_SFR;
            end
          end
        end
        default: state <= DEEAC_C_IDLE;
      endcase
    end
  end

  // Vector acknowledge and stack state towards the device
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus.irq_ack    <= 1'b0;
      bus.stack_full <= 1'b0;
      ack_q          <= 1'b0;
    end else begin
      // Request lags the service by a cycle; one acknowledge only
      bus.irq_ack    <= bus.irq_req && !bus.irq_ack && !ack_q;
      bus.stack_full <= stack_full_in;
      ack_q          <= bus.irq_ack;
    end
  end
endmodule

// ==== tb/deeac_checker.sv ====
`timescale 1ns/100ps
module deeac_checker
  import deeac_pkg::*;
#(
  parameter int RD_CYCLES = 4,
  parameter int TMR_DIV   = 125,
  parameter int WR_TICKS  = 8
) (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Core to device
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       irq_ack,
  input wire logic       stack_full,
  // Device to core
  input wire logic [7:0] sfr_rdata,
  input wire logic       irq_req
);
  // Slack covers timer phase and the core's polling gap
  localparam int GO_LIMIT = (WR_TICKS + 2) * TMR_DIV + RD_CYCLES + 16;
  logic       bank;
  logic [7:0] ptr;
  logic       ctrl_q;
  logic       ctrl_acc;
  int         go_cnt;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  assign ctrl_acc = (sfr_addr == DEEAC_IND1_SFR) && bank &&
                    (ptr == DEEAC_CTRL_OFFSET);

  // Shadow of the window, so control reads can be told apart
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank <= 1'b0;
      ptr  <= 8'h00;
    end else if (sfr_wr && sfr_addr == DEEAC_BANK_SFR) begin
      bank <= sfr_wdata[0];
    end else if (sfr_wr && sfr_addr == DEEAC_PTR1_SFR) begin
      ptr <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    ctrl_q <= ctrl_acc && !rst_in;
  end

  // Cycles since a poll first showed a go bit still set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      go_cnt <= 0;
    end else if (ctrl_q && (sfr_rdata[0] || sfr_rdata[2])) begin
      go_cnt <= go_cnt + 1;
    end else if (ctrl_q) begin
      go_cnt <= 0;
    end else if (go_cnt != 0) begin
      go_cnt <= go_cnt + 1;
    end
  end

  sequence s_launch;
    sfr_wr && ctrl_acc && sfr_wdata[2] && sfr_wdata[3];
  endsequence

  sequence s_poll;
    ctrl_acc;
  endsequence

  a_ctrl_upper_zero: assert property (
    ctrl_acc |=> sfr_rdata[7:4] == 4'h0)
    else $error("control unused bits not zero");
  a_addr_upper_zero: assert property (
    sfr_addr == DEEAC_ADDR_SFR |=> sfr_rdata[7:5] == 3'h0)
    else $error("address upper bits not zero");
  a_bank_upper_zero: assert property (
    sfr_addr == DEEAC_BANK_SFR |=> sfr_rdata[7:1] == 7'h00)
    else $error("bank upper bits not zero");
  a_stack_full_mask: assert property (
    stack_full |=> !irq_req)
    else $error("interrupt requested with full stack");
  a_gie_off_quiet: assert property (
    sfr_wr && sfr_addr == DEEAC_IRQ_SFR && !sfr_wdata[DEEAC_GIE_BIT]
    |-> ##2 !irq_req)
    else $error("interrupt requested with global enable off");
  a_ack_clears_irq: assert property (
    irq_ack |-> ##2 !irq_req)
    else $error("interrupt request stays after service");
  a_go_self_clear: assert property (
    go_cnt < GO_LIMIT)
    else $error("go bit never cleared by hardware");
  // Core unmasks interrupts in the cycle between launch and first poll
  a_launch_busy: assert property (
    s_launch ##2 s_poll |=> sfr_rdata[DEEAC_WR_GO_BIT])
    else $error("write finished at once after launch");
endmodule

// ==== tb/tb_data_eeprom_access_controller.sv ====
`timescale 1ns/100ps
module tb_data_eeprom_access_controller;
  import deeac_pkg::*;
  // Short timer tick keeps write cycles brief
  localparam int TDIV = 2;
  localparam int WTK  = 8;
  localparam int RDC  = 4;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       rd_req, wr_req, stack_full, done, ready, busy_a, vec_a;
  logic       busy_b, vec_b;
  logic [4:0] addr;
  logic [7:0] wdata, rd_data, v;
  int         n_errors = 0;
  int         n_compared = 0;
  int         seed = 15;
  int         cyc;
  int         mem[32];
  int         q[$];
  int         n_vec = 0;
  int         exp_vec = 0;
  logic       pend = 1'b0;

  deeac_if bus_a (.clk_in(clk_in), .rst_in(rst_in));
  deeac_if bus_b (.clk_in(clk_in), .rst_in(rst_in));
  deeac_core u_deeac_core (.clk_in(clk_in), .rst_in(rst_in),
    .bus(bus_a.core), .rd_req_in(rd_req), .wr_req_in(wr_req),
    .addr_in(addr), .data_in(wdata), .stack_full_in(stack_full),
    .done_out(done), .data_out(rd_data), .ready_out(ready));
  deeac_device #(.RD_CYCLES(RDC), .TMR_DIV(TDIV), .WR_TICKS(WTK))
    u_deeac_device (.clk_in(clk_in), .rst_in(rst_in),
    .bus(bus_a.device), .busy_out(busy_a), .vector_out(vec_a));
  // Second device, driven directly to commit faults on purpose
  deeac_device #(.RD_CYCLES(RDC), .TMR_DIV(TDIV), .WR_TICKS(WTK))
    u_deeac_device_b (.clk_in(clk_in), .rst_in(rst_in),
    .bus(bus_b.device), .busy_out(busy_b), .vector_out(vec_b));
  deeac_checker #(.RD_CYCLES(RDC), .TMR_DIV(TDIV), .WR_TICKS(WTK))
    u_deeac_checker (.clk_in(clk_in), .rst_in(rst_in),
    .sfr_wr(bus_a.sfr_wr), .sfr_rd(bus_a.sfr_rd),
    .sfr_addr(bus_a.sfr_addr), .sfr_wdata(bus_a.sfr_wdata),
    .irq_ack(bus_a.irq_ack), .stack_full(bus_a.stack_full),
    .sfr_rdata(bus_a.sfr_rdata), .irq_req(bus_a.irq_req));

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // Vector pulses last one cycle, so each is seen once
  always @(posedge clk_in) begin
    if (vec_a === 1'b1) begin
      n_vec++;
    end
  end

  task check(input string name, input logic [7:0] seen,
             input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task core_op(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 100) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    wr_req = w;
    rd_req = !w;
    addr = a;
    wdata = d;
    stack_full = 1'($random(seed));
    // A flag held back by a full stack is taken once it frees
    if (pend && !stack_full) begin
      exp_vec++;
      pend = 1'b0;
    end
    if (w && stack_full) begin
      pend = 1'b1;
    end else if (w) begin
      exp_vec++;
    end
    @(posedge clk_in);
    #1;
    wr_req = 1'b0;
    rd_req = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 2000) begin
      @(posedge clk_in);
      #1;
      cyc++;
    end
    if (i >= 100 || cyc >= 2000) begin
      n_errors++;
      finish_test();
    end
  endtask

  // Write strobe stays up until the next call; always end with a read
  task sw(input logic [7:0] a, input logic [7:0] d);
    bus_b.sfr_wr = 1'b1;
    bus_b.sfr_rd = 1'b0;
    bus_b.sfr_addr = a;
    bus_b.sfr_wdata = d;
    @(posedge clk_in);
    #1;
  endtask

  task sr(input logic [7:0] a);
    bus_b.sfr_wr = 1'b0;
    bus_b.sfr_rd = 1'b1;
    bus_b.sfr_addr = a;
    @(posedge clk_in);
    #1;
    v = bus_b.sfr_rdata;
  endtask

  task poll(input int b);
    int n;
    n = 0;
    do begin
      sr(DEEAC_IND1_SFR);
      n++;
    end while (v[b] && n < 500);
    if (n >= 500) begin
      n_errors++;
      finish_test();
    end
  endtask

  initial begin
    logic [4:0] a;
    int         i;
    {rd_req, wr_req, stack_full, addr, wdata} = '0;
    {bus_b.sfr_wr, bus_b.sfr_rd, bus_b.irq_ack, bus_b.stack_full} = '0;
    bus_b.sfr_addr = 8'h00;
    bus_b.sfr_wdata = 8'h00;
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    sr(DEEAC_BANK_SFR);
    check("bank", v, 8'h00);
    sw(DEEAC_PTR1_SFR, DEEAC_CTRL_OFFSET);
    sw(DEEAC_BANK_SFR, 8'h01);
    sr(DEEAC_IND1_SFR);
    check("ctrl", v, DEEAC_CTRL_RST);
    sw(DEEAC_IND1_SFR, 8'h04);
    sw(DEEAC_IND1_SFR, 8'h01);
    sr(DEEAC_IND1_SFR);
    check("ctrl", v, 8'h00);
    sw(DEEAC_ADDR_SFR, 8'hff);
    sr(DEEAC_ADDR_SFR);
    check("addr", v, 8'h1f);
    $display("test protection done");
    sw(DEEAC_IRQ_SFR, 8'h02);
    sw(DEEAC_ADDR_SFR, 8'h05);
    sw(DEEAC_DATA_SFR, 8'ha5);
    sw(DEEAC_IND1_SFR, 8'h08);
    sw(DEEAC_IND1_SFR, 8'h0c);
    sw(DEEAC_IND1_SFR, 8'h0f);
    check("busy", {7'h00, busy_b}, 8'h01);
    sw(DEEAC_IRQ_SFR, 8'h03);
    poll(DEEAC_WR_GO_BIT);
    check("ctrl", v, 8'h0a);
    check("busy", {7'h00, busy_b}, 8'h00);
    for (i = 0; i < 10 && bus_b.irq_req !== 1'b1; i++) begin
      @(posedge clk_in);
      #1;
    end
    check("irq_req", {7'h00, bus_b.irq_req}, 8'h01);
    sr(DEEAC_IRQ_SFR);
    check("irq", v, 8'h07);
    bus_b.irq_ack = 1'b1;
    @(posedge clk_in);
    #1;
    check("vector", {7'h00, vec_b}, 8'h01);
    bus_b.irq_ack = 1'b0;
    sr(DEEAC_IRQ_SFR);
    check("irq", v, 8'h02);
    sw(DEEAC_DATA_SFR, 8'h00);
    sw(DEEAC_IND1_SFR, 8'h02);
    sw(DEEAC_IND1_SFR, 8'h03);
    poll(DEEAC_RD_GO_BIT);
    sw(DEEAC_IND1_SFR, 8'h00);
    sr(DEEAC_DATA_SFR);
    check("data", v, 8'ha5);
    $display("test direct write and read done");
    for (i = 0; i < 4; i++) begin
      a = 5'($random(seed));
      mem[a] = $random(seed) & 8'hff;
      q.push_back(a);
      core_op(1'b1, a, 8'(mem[a]));
      check("wr_time", 8'(cyc >= (WTK - 1) * TDIV), 8'h01);
    end
    while (q.size() > 0) begin
      a = 5'(q.pop_front());
      core_op(1'b0, a, 8'h00);
      check("rd_data", rd_data, 8'(mem[a]));
      check("busy", {7'h00, busy_a}, 8'h00);
    end
    check("vectors", 8'(n_vec), 8'(exp_vec));
    $display("test core traffic done");
    finish_test();
  end
endmodule
